// ==== include/rfc_defines.vh ====
// Constants for the reference and feedback combiner
`ifndef RFC_DEFINES_VH
`define RFC_DEFINES_VH

// Data widths
`define RFC_DW            16
`define RFC_OW            32

// Clock rate and digipot step period
`define RFC_CLK_MHZ       10
`define RFC_DIGIPOT_US    10000
`define RFC_DIGIPOT_CYC   20'd100000
`define RFC_DIGIPOT_STEP  16'sh0001
`define RFC_DIGIPOT_MAX   16'sh7fff
`define RFC_DIGIPOT_MIN   16'sh8001

// Reset values
`define RFC_PRESET_RST    16'h0000
`define RFC_DIGIPOT_RST   16'h0000

// Reference source select codes
`define RFC_SRC_NONE      3'h0
`define RFC_SRC_AIN0      3'h1
`define RFC_SRC_AIN1      3'h2
`define RFC_SRC_PULSE     3'h3
`define RFC_SRC_DIGIPOT   3'h4

// Active reference modes
`define RFC_REF_EXT       2'h0
`define RFC_REF_PRESET    2'h1
`define RFC_REF_SUM       2'h2

// Feedback configurations
`define RFC_CFG_SINGLE    2'h0
`define RFC_CFG_MZONE     2'h1
`define RFC_CFG_MSETP     2'h2

// Feedback function codes
`define RFC_FB_FB1        4'h0
`define RFC_FB_FB2        4'h1
`define RFC_FB_FB3        4'h2
`define RFC_FB_SUM        4'h3
`define RFC_FB_DIFF       4'h4
`define RFC_FB_AVG        4'h5
`define RFC_FB_MIN        4'h6
`define RFC_FB_MAX        4'h7
`define RFC_FB_MSP_MIN    4'hd
`define RFC_FB_MSP_MAX    4'he

// Controller time settings, seconds
`define RFC_ITIME_OFF     16'h2710
`define RFC_DTIME_OFF     16'h0000

// Scaling divisor, percent
`define RFC_PCT_DIV       27'sd100

`endif

// ==== design/rfc_top.v ====
// Reference and feedback combiner for a closed-loop speed controller
// Function
// - Eight programmable presets, one active
// - Preset chosen by inputs or bus
// - Three source selects feed reference contributions
// - Digipot up, down, optional clear inputs
// - Contributions plus bus reference form total
// - Active reference: external, preset or sum
// - Final reference is X plus X*Y/100
// - Single zone: setpoint 1 plus reference
// - Multi-zone combines feedbacks; difference uses 1,2
// - Multi-zone single setpoint uses setpoint 1
// - Code 14 forwards smallest zone difference
// - Code 13 forwards largest zone difference
// - Zone difference is setpoint minus feedback
// - Differences compared as signed values
// - Optional square root feedback conversion
// - Integral 10000 s off, derivative 0 off
`timescale 1ns/10ps
`default_nettype none
`include "rfc_defines.vh"

module rfc_top #(
  parameter [19:0] DIGIPOT_CYC = `RFC_DIGIPOT_CYC
) (
  input  wire               CORE_CLK,
  input  wire               SRST,
  input  wire               PRESET_WR,
  input  wire [2:0]         PRESET_WR_IDX,
  input  wire [15:0]        PRESET_WR_VAL,
  input  wire               PRESET_FROM_BUS,
  input  wire [2:0]         DIN_PRESET,
  input  wire [2:0]         BUS_PRESET,
  input  wire [2:0]         SRC_SEL1,
  input  wire [2:0]         SRC_SEL2,
  input  wire [2:0]         SRC_SEL3,
  input  wire [15:0]        AIN0,
  input  wire [15:0]        AIN1,
  input  wire [15:0]        PULSE_REF,
  input  wire [15:0]        BUS_REF,
  input  wire               DIN_UP,
  input  wire               DIN_DOWN,
  input  wire               DIN_CLEAR,
  input  wire [1:0]         REF_MODE,
  input  wire [7:0]         REL_PCT,
  input  wire [1:0]         FB_CFG,
  input  wire [3:0]         FB_FUNC,
  input  wire               FB_THREE,
  input  wire [2:0]         SQRT_EN,
  input  wire [15:0]        FB1,
  input  wire [15:0]        FB2,
  input  wire [15:0]        FB3,
  input  wire [15:0]        SP1,
  input  wire [15:0]        SP2,
  input  wire [15:0]        SP3,
  input  wire [15:0]        ITIME,
  input  wire [15:0]        DTIME,
  output reg  [31:0]        REF_OUT,
  output reg  [31:0]        EXT_REF_OUT,
  output reg  [31:0]        SP_OUT,
  output reg  [31:0]        FB_OUT,
  output reg  [1:0]         ZONE_OUT,
  output reg  [2:0]         PRESET_ACT,
  output reg  [15:0]        DIGIPOT_OUT,
  output reg                INT_OFF,
  output reg                DER_OFF
);

  // Integer square root, digit by digit; 30-bit radicand, 15-bit root
  function [14:0] isqrt;
    input [29:0] val;
    reg   [29:0] rem;
    reg   [14:0] root;
    reg   [29:0] trial;
    integer      i;
    begin
      rem  = val;
      root = 15'h0000;
      for (i = 14; i >= 0; i = i - 1)
      begin
        trial = ({15'h0000, root} << (i + 1)) + (30'h00000001 << (2 * i));
        if (rem >= trial)
        begin
          rem  = rem - trial;
          root = root | (15'h0001 << i);
        end
      end
      isqrt = root;
    end
  endfunction

  // Pick one reference contribution by its source code
  function signed [15:0] src_pick;
    input [2:0]  sel;
    input [15:0] a0;
    input [15:0] a1;
    input [15:0] pl;
    input [15:0] dp;
    begin
      case (sel)
        `RFC_SRC_AIN0:    src_pick = a0;
        `RFC_SRC_AIN1:    src_pick = a1;
        `RFC_SRC_PULSE:   src_pick = pl;
        `RFC_SRC_DIGIPOT: src_pick = dp;
        default:          src_pick = 16'sh0000;
      endcase
    end
  endfunction

  // Pin synchronisers; first stage is read only by the second
  wire [5:0] pin_raw = {DIN_CLEAR, DIN_DOWN, DIN_UP, DIN_PRESET};
  reg  [5:0] pin_m_q;
  reg  [5:0] pin_s_q;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_sync
      always @(posedge CORE_CLK)
      begin
        if (SRST)
        begin
          pin_m_q[g] <= 1'b0;
          pin_s_q[g] <= 1'b0;
        end
        else
        begin
          pin_m_q[g] <= pin_raw[g];
          pin_s_q[g] <= pin_m_q[g];
        end
      end
    end
  endgenerate

  wire [2:0] din_preset_s = pin_s_q[2:0];
  wire       up_s         = pin_s_q[3];
  wire       down_s       = pin_s_q[4];
  wire       clear_s      = pin_s_q[5];

  // Preset store, written one entry at a time
  reg [15:0] preset_mem [0:7];
  integer    k;
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      for (k = 0; k < 8; k = k + 1)
        preset_mem[k] <= `RFC_PRESET_RST;
    end
    else if (PRESET_WR)
      preset_mem[PRESET_WR_IDX] <= PRESET_WR_VAL;
  end

  wire [2:0]         preset_idx = PRESET_FROM_BUS ? BUS_PRESET : din_preset_s;
  wire signed [15:0] preset_val = preset_mem[preset_idx];

  // Digipot: one step per period so a held input ramps at a usable rate
  reg         [19:0] dp_cnt_q;
  reg  signed [15:0] dp_q;
  wire               dp_tick = (dp_cnt_q >= DIGIPOT_CYC - 20'h00001);
  always @(posedge CORE_CLK)
  begin
    if (SRST || !(up_s ^ down_s))
      dp_cnt_q <= 20'h00000;
    else if (dp_tick)
      dp_cnt_q <= 20'h00000;
    else
      dp_cnt_q <= dp_cnt_q + 20'h00001;
  end

  always @(posedge CORE_CLK)
  begin
    if (SRST)
      dp_q <= `RFC_DIGIPOT_RST;
    else if (clear_s)                    // Clear overrides ramping
      dp_q <= `RFC_DIGIPOT_RST;
    else if (dp_tick && up_s && !down_s && dp_q != `RFC_DIGIPOT_MAX)
      dp_q <= dp_q + `RFC_DIGIPOT_STEP;
    else if (dp_tick && down_s && !up_s && dp_q != `RFC_DIGIPOT_MIN)
      dp_q <= dp_q - `RFC_DIGIPOT_STEP;
  end

  wire signed [15:0] c1 = src_pick(SRC_SEL1, AIN0, AIN1, PULSE_REF, dp_q);
  wire signed [15:0] c2 = src_pick(SRC_SEL2, AIN0, AIN1, PULSE_REF, dp_q);
  wire signed [15:0] c3 = src_pick(SRC_SEL3, AIN0, AIN1, PULSE_REF, dp_q);

  // external sum, 18 bits holds four terms
  wire signed [17:0] ext_sum = {{2{c1[15]}}, c1} + {{2{c2[15]}}, c2}
                             + {{2{c3[15]}}, c3} + {{2{BUS_REF[15]}}, BUS_REF};

  reg signed [18:0] act_x;
  always @*
  begin
    case (REF_MODE)
      `RFC_REF_EXT:    act_x = {ext_sum[17], ext_sum};
      `RFC_REF_PRESET: act_x = {{3{preset_val[15]}}, preset_val};
      `RFC_REF_SUM:    act_x = {ext_sum[17], ext_sum} + {{3{preset_val[15]}}, preset_val};
      default:         act_x = {ext_sum[17], ext_sum};
    endcase
  end

  // relative scaling; division truncates toward zero
  wire signed [7:0]  rel_y   = REL_PCT;
  wire signed [26:0] prod    = {{8{act_x[18]}}, act_x} * {{19{rel_y[7]}}, rel_y};
  wire signed [26:0] scaled  = prod / `RFC_PCT_DIV;
  wire signed [27:0] fin_ref = {{9{act_x[18]}}, act_x} + {scaled[26], scaled};

  // square root per feedback; radicand shifted up 15 bits for resolution
  wire [15:0] fb_raw [0:2];
  wire [15:0] fb_c   [0:2];
  assign fb_raw[0] = FB1;
  assign fb_raw[1] = FB2;
  assign fb_raw[2] = FB3;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_conv
      // Negative pressure has no root; it maps to zero
      assign fb_c[g] = !SQRT_EN[g] ? fb_raw[g] :
                       fb_raw[g][15] ? 16'h0000 :
                       {1'b0, isqrt({fb_raw[g][14:0], 15'h0000})};
    end
  endgenerate

  wire signed [17:0] f1 = {{2{fb_c[0][15]}}, fb_c[0]};
  wire signed [17:0] f2 = {{2{fb_c[1][15]}}, fb_c[1]};
  wire signed [17:0] f3 = FB_THREE ? {{2{fb_c[2][15]}}, fb_c[2]} : 18'sh00000;
  wire signed [17:0] f3m = {{2{fb_c[2][15]}}, fb_c[2]};
  wire signed [17:0] fsum = f1 + f2 + f3;
  wire signed [17:0] favg = fsum / (FB_THREE ? 18'sd3 : 18'sd2);
  wire signed [17:0] fmn12 = (f1 < f2) ? f1 : f2;
  wire signed [17:0] fmx12 = (f1 > f2) ? f1 : f2;

  wire signed [17:0] d1 = {{2{SP1[15]}}, SP1} - f1;
  wire signed [17:0] d2 = {{2{SP2[15]}}, SP2} - f2;
  wire signed [17:0] d3 = {{2{SP3[15]}}, SP3} - f3m;

  // signed zone ranking; ties keep the lower zone
  reg [1:0] zsel;
  always @*
  begin
    if (FB_FUNC == `RFC_FB_MSP_MAX)
    begin
      zsel = (d2 < d1) ? 2'h1 : 2'h0;
      if (FB_THREE && d3 < ((d2 < d1) ? d2 : d1))
        zsel = 2'h2;
    end
    else
    begin
      zsel = (d2 > d1) ? 2'h1 : 2'h0;
      if (FB_THREE && d3 > ((d2 > d1) ? d2 : d1))
        zsel = 2'h2;
    end
  end

  // Feedback and setpoint selection per configuration
  reg signed [17:0] fb_sel;
  reg signed [31:0] sp_sel;
  reg        [1:0]  zone_sel;
  always @*
  begin
    fb_sel   = f1;
    zone_sel = 2'h0;
    sp_sel   = {{16{SP1[15]}}, SP1};
    case (FB_CFG)
      `RFC_CFG_SINGLE:
      begin
        sp_sel = {{16{SP1[15]}}, SP1} + {{4{fin_ref[27]}}, fin_ref};
        case (FB_FUNC)
          `RFC_FB_FB2: fb_sel = f2;
          `RFC_FB_FB3: fb_sel = f3m;
          default:     fb_sel = f1;
        endcase
      end
      `RFC_CFG_MZONE:
      begin
        case (FB_FUNC)
          `RFC_FB_SUM:  fb_sel = fsum;
          `RFC_FB_DIFF: fb_sel = f1 - f2;
          `RFC_FB_AVG:  fb_sel = favg;
          `RFC_FB_MIN:  fb_sel = (FB_THREE && f3m < fmn12) ? f3m : fmn12;
          `RFC_FB_MAX:  fb_sel = (FB_THREE && f3m > fmx12) ? f3m : fmx12;
          default:      fb_sel = f1;
        endcase
      end
      `RFC_CFG_MSETP:
      begin
        zone_sel = zsel;
        case (zsel)
          2'h1:
          begin
            fb_sel = f2;
            sp_sel = {{16{SP2[15]}}, SP2};
          end
          2'h2:
          begin
            fb_sel = f3m;
            sp_sel = {{16{SP3[15]}}, SP3};
          end
          default:
          begin
            fb_sel = f1;
            sp_sel = {{16{SP1[15]}}, SP1};
          end
        endcase
      end
      default:
      begin
        fb_sel = f1;
      end
    endcase
  end

  // Output registers, one cycle after the same-domain inputs
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      REF_OUT     <= 32'h00000000;
      EXT_REF_OUT <= 32'h00000000;
      SP_OUT      <= 32'h00000000;
      FB_OUT      <= 32'h00000000;
      ZONE_OUT    <= 2'h0;
      PRESET_ACT  <= 3'h0;
      DIGIPOT_OUT <= 16'h0000;
      INT_OFF     <= 1'b0;
      DER_OFF     <= 1'b0;
    end
    else
    begin
      REF_OUT     <= {{4{fin_ref[27]}}, fin_ref};
      EXT_REF_OUT <= {{14{ext_sum[17]}}, ext_sum};
      SP_OUT      <= sp_sel;
      FB_OUT      <= {{14{fb_sel[17]}}, fb_sel};
      ZONE_OUT    <= zone_sel;
      PRESET_ACT  <= preset_idx;
      DIGIPOT_OUT <= dp_q;
      INT_OFF     <= (ITIME == `RFC_ITIME_OFF);
      DER_OFF     <= (DTIME == `RFC_DTIME_OFF);
    end
  end

endmodule

`default_nettype wire

// ==== verif/rfc_top_monitor.sv ====
// Port-level checker for the reference and feedback combiner
`timescale 1ns/10ps
`default_nettype none
module rfc_top_monitor #(
  parameter [19:0] DIGIPOT_CYC = 20'h4
) (
  input wire logic        CORE_CLK,
  input wire logic        SRST,
  input wire logic        PRESET_FROM_BUS,
  input wire logic [2:0]  BUS_PRESET,
  input wire logic [2:0]  PRESET_ACT,
  input wire logic        DIN_CLEAR,
  input wire logic [15:0] DIGIPOT_OUT,
  input wire logic [1:0]  REF_MODE,
  input wire logic [7:0]  REL_PCT,
  input wire logic [31:0] REF_OUT,
  input wire logic [31:0] EXT_REF_OUT,
  input wire logic [1:0]  FB_CFG,
  input wire logic [3:0]  FB_FUNC,
  input wire logic        FB_THREE,
  input wire logic [2:0]  SQRT_EN,
  input wire logic [15:0] SP1,
  input wire logic [15:0] SP2,
  input wire logic [15:0] FB1,
  input wire logic [15:0] FB2,
  input wire logic [31:0] SP_OUT,
  input wire logic [1:0]  ZONE_OUT,
  input wire logic [15:0] ITIME,
  input wire logic [15:0] DTIME,
  input wire logic        INT_OFF,
  input wire logic        DER_OFF
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  logic [1:0]         run_q;
  logic signed [16:0] d0;
  logic signed [16:0] d1;
  // Outputs are trusted only two edges after reset, so stale values never count
  always_ff @(posedge CORE_CLK)
    run_q <= SRST ? 2'h0 : {run_q[0], 1'h1};
  // Zone differences are signed, a feedback above setpoint goes negative
  assign d0 = $signed(SP1) - $signed(FB1);
  assign d1 = $signed(SP2) - $signed(FB2);
  sequence s_two_zone;
    run_q[1] && $past(FB_CFG) == 2'h2 && !$past(FB_THREE) && $past(SQRT_EN) == 3'h0;
  endsequence
  sequence s_clear_held;
    DIN_CLEAR [*4];
  endsequence
  // Each output tied to its inputs one edge earlier, except the digipot clear and step checks
  int_off_a: assert property (run_q[1] |-> INT_OFF == ($past(ITIME) == 16'h2710))
    else $error("integral off flag wrong");
  der_off_a: assert property (run_q[1] |-> DER_OFF == ($past(DTIME) == 16'h0))
    else $error("derivative off flag wrong");
  ref_scale_a: assert property (run_q[1] && $past(REF_MODE) == 2'h0 |->
    $signed(REF_OUT) == $signed(EXT_REF_OUT) + $signed(EXT_REF_OUT) * $signed($past(REL_PCT)) / 100)
    else $error("scaled reference wrong");
  preset_bus_a: assert property (run_q[1] && $past(PRESET_FROM_BUS) |->
    PRESET_ACT == $past(BUS_PRESET))
    else $error("bus preset not followed");
  zone_least_a: assert property (s_two_zone ##0 $past(FB_FUNC) == 4'he |->
    ZONE_OUT == ($past(d1 < d0) ? 2'h1 : 2'h0))
    else $error("least difference zone wrong");
  zone_most_a: assert property (s_two_zone ##0 $past(FB_FUNC) == 4'hd |->
    ZONE_OUT == ($past(d1 > d0) ? 2'h1 : 2'h0))
    else $error("greatest difference zone wrong");
  zone_idle_a: assert property (run_q[1] && $past(FB_CFG) != 2'h2 |-> ZONE_OUT == 2'h0)
    else $error("zone set outside multi setpoint");
  mz_setpoint_a: assert property (run_q[1] && $past(FB_CFG) == 2'h1 |->
    $signed(SP_OUT) == $signed($past(SP1)))
    else $error("multi zone setpoint not setpoint 1");
  pot_clear_a: assert property (run_q[1] ##0 s_clear_held |=> DIGIPOT_OUT == 16'h0)
    else $error("digipot not cleared");
  pot_step_a: assert property (run_q[1] |-> $stable(DIGIPOT_OUT) || DIGIPOT_OUT == 16'h0 ||
    DIGIPOT_OUT - $past(DIGIPOT_OUT) == 16'h1 || $past(DIGIPOT_OUT) - DIGIPOT_OUT == 16'h1)
    else $error("digipot jumped");
endmodule
`default_nettype wire

// ==== verif/rfc_field.sv ====
// Field sensor model driving the three feedback lines
`timescale 1ns/10ps
`default_nettype none
module rfc_field (
  output var logic [15:0] fb1,
  output var logic [15:0] fb2,
  output var logic [15:0] fb3
);
  // Sensors hold a reading until the bench moves them off a clock edge
  initial {fb1, fb2, fb3} = 48'h0;
  task automatic put(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    {fb1, fb2, fb3} = {a, b, c};
  endtask
endmodule
`default_nettype wire

// ==== verif/test_rfc_top.sv ====
// Self-checking bench for the reference and feedback combiner
`timescale 1ns/10ps
`default_nettype none
module test_rfc_top;
  logic        clk, srst, wr, from_bus, three, up, down, clr;
  logic [2:0]  wr_idx, din_pre, bus_pre, sel1, sel2, sel3, sqrt_en;
  logic [1:0]  ref_mode, fb_cfg;
  logic [3:0]  fb_func;
  logic [7:0]  pct;
  logic [15:0] wr_val, ain0, ain1, pulse, bus_ref, sp1, sp2, sp3, itime, dtime;
  wire  [15:0] fb1, fb2, fb3, pot;
  wire  [31:0] ref_o, ext_o, sp_o, fb_o;
  wire  [2:0]  pre_act;
  wire  [1:0]  zone;
  wire         int_off, der_off;
  int          n_errors, n_compared;
  rfc_field u_field (.fb1(fb1), .fb2(fb2), .fb3(fb3));
  // Short digipot step keeps ramps within a few cycles
  rfc_top #(.DIGIPOT_CYC(20'h4)) dut (
    .CORE_CLK(clk), .SRST(srst), .PRESET_WR(wr), .PRESET_WR_IDX(wr_idx), .PRESET_WR_VAL(wr_val),
    .PRESET_FROM_BUS(from_bus), .DIN_PRESET(din_pre), .BUS_PRESET(bus_pre), .SRC_SEL1(sel1),
    .SRC_SEL2(sel2), .SRC_SEL3(sel3), .AIN0(ain0), .AIN1(ain1), .PULSE_REF(pulse),
    .BUS_REF(bus_ref), .DIN_UP(up), .DIN_DOWN(down), .DIN_CLEAR(clr), .REF_MODE(ref_mode),
    .REL_PCT(pct), .FB_CFG(fb_cfg), .FB_FUNC(fb_func), .FB_THREE(three), .SQRT_EN(sqrt_en),
    .FB1(fb1), .FB2(fb2), .FB3(fb3), .SP1(sp1), .SP2(sp2), .SP3(sp3), .ITIME(itime),
    .DTIME(dtime), .REF_OUT(ref_o), .EXT_REF_OUT(ext_o), .SP_OUT(sp_o), .FB_OUT(fb_o),
    .ZONE_OUT(zone), .PRESET_ACT(pre_act), .DIGIPOT_OUT(pot), .INT_OFF(int_off),
    .DER_OFF(der_off));
  always #50 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Three sources plus bus word, then negative scaling
  task automatic t_ext;
    {ain0, ain1, pulse, bus_ref} = {16'h0064, 16'hffec, 16'h0005, 16'h000f};
    {sel1, sel2, sel3, ref_mode, pct} = {3'h1, 3'h2, 3'h3, 2'h0, 8'h0a};
    tick(1);
    chk(ext_o, 32'h64);
    chk(ref_o, 32'h6e);
    pct = 8'hce;
    tick(1);
    chk(ref_o, 32'h32);
  endtask
  // Back-to-back preset writes, bus then pin selection
  task automatic t_pre;
    {wr, wr_idx, wr_val} = {1'h1, 3'h7, 16'h012c};
    tick(1);
    {wr_idx, wr_val} = {3'h2, 16'h01f4};
    tick(1);
    {wr, from_bus, bus_pre, ref_mode, pct} = {1'h0, 1'h1, 3'h2, 2'h1, 8'h0};
    tick(2);
    chk(ref_o, 32'h1f4);
    chk({29'h0, pre_act}, 32'h2);
    bus_pre = 3'h7;
    tick(1);
    chk(ref_o, 32'h12c);
    {from_bus, din_pre, ref_mode} = {1'h0, 3'h2, 2'h2};
    tick(4);
    chk({29'h0, pre_act}, 32'h2);
    chk(ref_o, 32'h258);
  endtask
  // Single zone adds the reference; square root on feedbacks 1 and 3
  task automatic t_single;
    u_field.put(16'h0037, 16'h002e, 16'h0005);
    {sp1, sp2, sp3, fb_cfg, fb_func} = {16'h0096, 16'h002c, 16'h00c8, 2'h0, 4'h1};
    tick(1);
    chk(sp_o, 32'h2ee);
    chk(fb_o, 32'h2e);
    u_field.put(16'h0002, 16'h002e, 16'h0005);
    {fb_func, sqrt_en} = {4'h0, 3'h1};
    tick(1);
    chk(fb_o, 32'h100);
    u_field.put(16'h0037, 16'h002e, 16'h0005);
    {fb_func, sqrt_en} = {4'h2, 3'h4};
    tick(1);
    chk(fb_o, 32'h194);
    sqrt_en = 3'h0;
  endtask
  // Every combining function over three feedbacks
  task automatic t_mz;
    logic [3:0]  f[5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [31:0] e[5] = '{32'h6a, 32'h9, 32'h23, 32'h5, 32'h37};
    {fb_cfg, three} = {2'h1, 1'h1};
    foreach (f[i])
    begin
      fb_func = f[i];
      tick(1);
      chk(fb_o, e[i]);
      chk(sp_o, 32'h96);
    end
  endtask
  // Zone 2 runs above its setpoint, so its difference is negative
  task automatic t_msp;
    {fb_cfg, three, fb_func} = {2'h2, 1'h0, 4'he};
    tick(1);
    chk({30'h0, zone}, 32'h1);
    chk(sp_o, 32'h2c);
    chk(fb_o, 32'h2e);
    fb_func = 4'hd;
    tick(1);
    chk({30'h0, zone}, 32'h0);
    chk(fb_o, 32'h37);
    three = 1'h1;
    tick(1);
    chk({30'h0, zone}, 32'h2);
  endtask
  task automatic t_time;
    {itime, dtime} = {16'h2710, 16'h0};
    tick(1);
    chk({30'h0, int_off, der_off}, 32'h3);
    {itime, dtime} = {16'h270f, 16'h1};
    tick(1);
    chk({30'h0, int_off, der_off}, 32'h0);
    {itime, dtime} = {16'h0050, 16'h0014};
    tick(1);
    chk({30'h0, int_off, der_off}, 32'h0);
  endtask
  // Ramp up, hold with both pins, clear overrides
  task automatic t_pot;
    int k = 0;
    {sel1, sel2, sel3, bus_ref, ref_mode, pct} = {3'h4, 3'h5, 3'h0, 16'h0, 2'h0, 8'h0};
    up = 1'h1;
    while (pot !== 16'h2 && k < 40)
    begin
      tick(1);
      k++;
    end
    down = 1'h1;
    tick(12);
    chk({16'h0, pot}, 32'h2);
    chk(ext_o, 32'h2);
    clr = 1'h1;
    tick(4);
    chk({16'h0, pot}, 32'h0);
    {up, clr} = 2'h0;
    k = 0;
    while (pot !== 16'hffff && k < 40)
    begin
      tick(1);
      k++;
    end
    chk({16'h0, pot}, 32'hffff);
    chk(ext_o, 32'hffffffff);
    down = 1'h0;
  endtask
  initial
  begin
    {clk, srst, wr, from_bus, three, up, down, clr} = 8'h40;
    {wr_idx, din_pre, bus_pre, sel1, sel2, sel3, sqrt_en} = 21'h0;
    {ref_mode, fb_cfg, fb_func, pct} = 16'h0;
    {wr_val, ain0, ain1, pulse, bus_ref} = 80'h0;
    {sp1, sp2, sp3, itime, dtime} = 80'h1400001;
    tick(4);
    srst = 1'h0;
    tick(1);
    t_ext();
    t_pre();
    t_single();
    t_mz();
    t_msp();
    t_time();
    t_pot();
    close_out();
  end
  // Whole run needs about 65 cycles
  initial
  begin
    repeat (400) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule
bind rfc_top rfc_top_monitor #(.DIGIPOT_CYC(DIGIPOT_CYC)) u_mon (.CORE_CLK, .SRST,
  .PRESET_FROM_BUS, .BUS_PRESET, .PRESET_ACT, .DIN_CLEAR, .DIGIPOT_OUT, .REF_MODE, .REL_PCT,
  .REF_OUT, .EXT_REF_OUT, .FB_CFG, .FB_FUNC, .FB_THREE, .SQRT_EN, .SP1, .SP2, .FB1, .FB2,
  .SP_OUT, .ZONE_OUT, .ITIME, .DTIME, .INT_OFF, .DER_OFF);
`default_nettype wire
